// File: hdl/nvs_host.sv
// host controller issuing reads, writes and nonvolatile save/restore
`timescale 1ns/100ps
`default_nettype none
`include "nvs_consts.svh"

module nvs_host #(
	parameter int unsigned STORE_CYC = `NVS_STORE_CYC,
	parameter int unsigned RECALL_CYC = `NVS_RECALL_CYC_DEF
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_i,
	input wire logic [`NVS_ADDR_W-1:0] cmd_addr_i,
	input wire logic [`NVS_DATA_W-1:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic done_o,
	output logic [`NVS_DATA_W-1:0] rdata_o,
	output logic nv_busy_o,
	output logic ce_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [`NVS_ADDR_W-1:0] addr_o,
	output logic [`NVS_DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	input wire logic [`NVS_DATA_W-1:0] dq_i
);

	//------------------------------------------------------------
	// trigger address lookup
	//------------------------------------------------------------
	function automatic logic [`NVS_LOW_W-1:0] seq_addr(
		input logic [2:0] step,
		input logic restore
	);
		logic [`NVS_LOW_W-1:0] a;
		case (step)
			3'h0: a = `NVS_SEQ_A0;
			3'h1: a = `NVS_SEQ_A1;
			3'h2: a = `NVS_SEQ_A2;
			3'h3: a = `NVS_SEQ_A3;
			3'h4: a = `NVS_SEQ_A4;
			default: a = restore ? `NVS_SEQ_RESTORE : `NVS_SEQ_SAVE;
		endcase
		return a;
	endfunction : seq_addr

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	typedef struct packed {
		nvs_pkg::nvs_state_e state;
		logic [2:0] step;
		logic restore;
		logic [`NVS_CNT_W-1:0] cnt;
		logic ready;
		logic done;
		logic [`NVS_DATA_W-1:0] rdata;
		logic nv_busy;
		logic start;
		logic write;
		logic [`NVS_ADDR_W-1:0] addr;
		logic [`NVS_DATA_W-1:0] wdata;
	} nvs_host_s;

	nvs_host_s host_reg;
	nvs_host_s host_next;
	logic cyc_done;
	logic [`NVS_DATA_W-1:0] cyc_rdata;

	always_comb begin
		host_next = host_reg;
		host_next.done = 1'b0;
		host_next.start = 1'b0;
		case (host_reg.state)
			nvs_pkg::NVS_ST_IDLE: begin
				host_next.ready = 1'b1;
				if (cmd_valid_i && host_reg.ready) begin
					host_next.ready = 1'b0;
					host_next.start = 1'b1;
					if (cmd_i == nvs_pkg::NVS_CMD_READ ||
					    cmd_i == nvs_pkg::NVS_CMD_WRITE) begin
						host_next.write = (cmd_i == nvs_pkg::NVS_CMD_WRITE);
						host_next.addr = cmd_addr_i;
						host_next.wdata = cmd_wdata_i;
						host_next.state = nvs_pkg::NVS_ST_ACCESS;
					end else begin
						host_next.restore = (cmd_i == nvs_pkg::NVS_CMD_RESTORE);
						host_next.step = 3'h0;
						host_next.write = 1'b0;
						// top address bit is ignored, driven low
						host_next.addr = {1'b0, seq_addr(3'h0,
							cmd_i == nvs_pkg::NVS_CMD_RESTORE)};
						host_next.nv_busy = 1'b1;
						host_next.state = nvs_pkg::NVS_ST_SEQ;
					end
				end
			end
			nvs_pkg::NVS_ST_ACCESS: begin
				if (cyc_done) begin
					host_next.done = 1'b1;
					host_next.rdata = cyc_rdata;
					host_next.state = nvs_pkg::NVS_ST_IDLE;
				end
			end
			nvs_pkg::NVS_ST_SEQ: begin
				// commands refused here: nothing may interleave
				if (cyc_done) begin
					host_next.rdata = cyc_rdata;
					if (host_reg.step == `NVS_SEQ_LAST) begin
						host_next.state = nvs_pkg::NVS_ST_WAIT;
						if (host_reg.restore) begin
							host_next.cnt = `NVS_CNT_W'(RECALL_CYC - 1);
						end else begin
							host_next.cnt = `NVS_CNT_W'(STORE_CYC - 1);
						end
					end else begin
						// next step issued at once, back to back
						host_next.step = host_reg.step + 3'h1;
						host_next.start = 1'b1;
						host_next.write = 1'b0;
						host_next.addr = {1'b0, seq_addr(host_reg.step + 3'h1,
							host_reg.restore)};
					end
				end
			end
			nvs_pkg::NVS_ST_WAIT: begin
				// device inputs and outputs are off: no access allowed
				if (host_reg.cnt == '0) begin
					host_next.done = 1'b1;
					host_next.nv_busy = 1'b0;
					host_next.state = nvs_pkg::NVS_ST_IDLE;
				end else begin
					host_next.cnt = host_reg.cnt - `NVS_CNT_W'(1);
				end
			end
			default: begin
				host_next.state = nvs_pkg::NVS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_reg <= '0;
		end else begin
			host_reg <= host_next;
		end
	end

	//------------------------------------------------------------
	// pin sequencer
	//------------------------------------------------------------
	nvs_cycle u_cycle (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(host_reg.start),
		.write_i(host_reg.write),
		.addr_i(host_reg.addr),
		.wdata_i(host_reg.wdata),
		.dq_i(dq_i),
		.ce_n_o(ce_n_o),
		.we_n_o(we_n_o),
		.oe_n_o(oe_n_o),
		.addr_o(addr_o),
		.dq_o(dq_o),
		.dq_oe_o(dq_oe_o),
		.done_o(cyc_done),
		.rdata_o(cyc_rdata)
	);

	assign cmd_ready_o = host_reg.ready;
	assign done_o = host_reg.done;
	assign rdata_o = host_reg.rdata;
	assign nv_busy_o = host_reg.nv_busy;

endmodule : nvs_host
`default_nettype wire

// File: hdl/nvs_consts.svh
// timing counts, trigger addresses and pin layout for the nvs host
//----------------------------------------------------------------
// What this block does
//----------------------------------------------------------------
`ifndef NVS_CONSTS_SVH
`define NVS_CONSTS_SVH

//----------------------------------------------------------------
// trigger addresses, low 14 bits
//----------------------------------------------------------------
`define NVS_SEQ_A0 14'h0E38
`define NVS_SEQ_A1 14'h31C7
`define NVS_SEQ_A2 14'h03E0
`define NVS_SEQ_A3 14'h3C1F
`define NVS_SEQ_A4 14'h303F
`define NVS_SEQ_SAVE 14'h0FC0
`define NVS_SEQ_RESTORE 14'h0C63
`define NVS_SEQ_LAST 3'h5

//----------------------------------------------------------------
// pin widths
//----------------------------------------------------------------
`define NVS_ADDR_W 15
`define NVS_LOW_W 14
`define NVS_DATA_W 8

//----------------------------------------------------------------
// timing
//----------------------------------------------------------------
`define NVS_CLK_NS 40
`define NVS_T_RC_NS 45
`define NVS_ACC_CYC ((`NVS_T_RC_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_T_STORE_MS 10
`define NVS_STORE_CYC (`NVS_T_STORE_MS * 1000000 / `NVS_CLK_NS)
`define NVS_RECALL_CYC_DEF 1000
`define NVS_CNT_W 24

`endif

// File: hdl/nvs_pkg.sv
// types shared by the nvs host modules
`default_nettype none
package nvs_pkg;

	typedef enum logic [1:0] {
		NVS_CMD_READ = 2'h0,
		NVS_CMD_WRITE = 2'h1,
		NVS_CMD_SAVE = 2'h2,
		NVS_CMD_RESTORE = 2'h3
	} nvs_cmd_e;

	typedef enum logic [1:0] {
		NVS_PH_IDLE = 2'h0,
		NVS_PH_SETUP = 2'h1,
		NVS_PH_ACT = 2'h2,
		NVS_PH_END = 2'h3
	} nvs_phase_e;

	typedef enum logic [1:0] {
		NVS_ST_IDLE = 2'h0,
		NVS_ST_ACCESS = 2'h1,
		NVS_ST_SEQ = 2'h2,
		NVS_ST_WAIT = 2'h3
	} nvs_state_e;

endpackage : nvs_pkg
`default_nettype wire

// File: hdl/nvs_cycle.sv
// one chip-enable controlled read or write on the memory pins
`timescale 1ns/100ps
`default_nettype none
`include "nvs_consts.svh"

module nvs_cycle (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [`NVS_ADDR_W-1:0] addr_i,
	input wire logic [`NVS_DATA_W-1:0] wdata_i,
	input wire logic [`NVS_DATA_W-1:0] dq_i,
	output logic ce_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [`NVS_ADDR_W-1:0] addr_o,
	output logic [`NVS_DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic done_o,
	output logic [`NVS_DATA_W-1:0] rdata_o
);

	typedef struct packed {
		nvs_pkg::nvs_phase_e phase;
		logic [3:0] cnt;
		logic wr;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [`NVS_ADDR_W-1:0] addr;
		logic [`NVS_DATA_W-1:0] dq;
		logic dq_oe;
		logic done;
		logic [`NVS_DATA_W-1:0] rdata;
		logic [`NVS_DATA_W-1:0] s1;
		logic [`NVS_DATA_W-1:0] s2;
		logic [`NVS_DATA_W-1:0] s3;
	} nvs_cyc_s;

	nvs_cyc_s cyc_reg;
	nvs_cyc_s cyc_next;

	always_comb begin
		cyc_next = cyc_reg;
		cyc_next.done = 1'b0;
		cyc_next.s1 = dq_i;
		cyc_next.s2 = cyc_reg.s1;
		cyc_next.s3 = cyc_reg.s2;
		case (cyc_reg.phase)
			nvs_pkg::NVS_PH_IDLE: begin
				if (start_i) begin
					cyc_next.phase = nvs_pkg::NVS_PH_SETUP;
					cyc_next.wr = write_i;
					cyc_next.addr = addr_i;
					cyc_next.dq = wdata_i;
					cyc_next.dq_oe = write_i;
					cyc_next.we_n = ~write_i;
					cyc_next.oe_n = write_i;
				end
			end
			nvs_pkg::NVS_PH_SETUP: begin
				// address settled one cycle with chip enable high
				cyc_next.ce_n = 1'b0;
				cyc_next.phase = nvs_pkg::NVS_PH_ACT;
				if (cyc_reg.wr) begin
					cyc_next.cnt = 4'(`NVS_ACC_CYC - 1);
				end else begin
					cyc_next.cnt = 4'(`NVS_ACC_CYC + 1);
				end
			end
			nvs_pkg::NVS_PH_ACT: begin
				if (cyc_reg.cnt != 4'h0) begin
					cyc_next.cnt = cyc_reg.cnt - 4'h1;
				end else if (cyc_reg.wr || cyc_reg.s2 == cyc_reg.s3) begin
					// wait for synchroniser agreement before sampling
					cyc_next.ce_n = 1'b1;
					cyc_next.phase = nvs_pkg::NVS_PH_END;
					if (!cyc_reg.wr) begin
						cyc_next.rdata = cyc_reg.s3;
					end
				end
			end
			nvs_pkg::NVS_PH_END: begin
				// controls released one cycle after chip enable rises: one-cycle hold
				cyc_next.we_n = 1'b1;
				cyc_next.oe_n = 1'b1;
				cyc_next.dq_oe = 1'b0;
				cyc_next.done = 1'b1;
				cyc_next.phase = nvs_pkg::NVS_PH_IDLE;
			end
			default: begin
				cyc_next.phase = nvs_pkg::NVS_PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_reg <= '0;
			cyc_reg.ce_n <= 1'b1;
			cyc_reg.we_n <= 1'b1;
			cyc_reg.oe_n <= 1'b1;
		end else begin
			cyc_reg <= cyc_next;
		end
	end

	assign ce_n_o = cyc_reg.ce_n;
	assign we_n_o = cyc_reg.we_n;
	assign oe_n_o = cyc_reg.oe_n;
	assign addr_o = cyc_reg.addr;
	assign dq_o = cyc_reg.dq;
	assign dq_oe_o = cyc_reg.dq_oe;
	assign done_o = cyc_reg.done;
	assign rdata_o = cyc_reg.rdata;

endmodule : nvs_cycle
`default_nettype wire

// File: verif/nvs_host_properties.sv
// concurrent checks on the nvs host memory pins
`timescale 1ns/100ps
`default_nettype none
`include "nvs_consts.svh"
module nvs_host_properties #(
	parameter int unsigned STORE_CYC = 20,
	parameter int unsigned RECALL_CYC = 10
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_i,
	input wire logic cmd_ready_o,
	input wire logic done_o,
	input wire logic nv_busy_o,
	input wire logic ce_n_o,
	input wire logic we_n_o,
	input wire logic oe_n_o,
	input wire logic [`NVS_ADDR_W-1:0] addr_o,
	input wire logic dq_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [2:0] step_reg;
	logic restore_reg;
	int unsigned wait_cnt;
	function automatic logic [13:0] exp_addr(input logic [2:0] s,
		input logic r);
		case (s)
			3'h0: return `NVS_SEQ_A0;
			3'h1: return `NVS_SEQ_A1;
			3'h2: return `NVS_SEQ_A2;
			3'h3: return `NVS_SEQ_A3;
			3'h4: return `NVS_SEQ_A4;
			default: return r ? `NVS_SEQ_RESTORE : `NVS_SEQ_SAVE;
		endcase
	endfunction : exp_addr
	// step count follows each closing chip-enable cycle of a sequence
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_reg <= 3'h0;
			restore_reg <= 1'b0;
		end else if (cmd_valid_i && cmd_ready_o) begin
			step_reg <= 3'h0;
			restore_reg <= (cmd_i == nvs_pkg::NVS_CMD_RESTORE);
		end else if (nv_busy_o && $rose(ce_n_o)) begin
			step_reg <= step_reg + 3'h1;
		end
	end
	// quiet cycles after the sixth step, against the nonvolatile time
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_cnt <= 0;
		end else if (cmd_valid_i && cmd_ready_o) begin
			wait_cnt <= 0;
		end else if (nv_busy_o && step_reg == 3'h6) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	a_seq_addr: assert property (
		nv_busy_o && $fell(ce_n_o) |->
		addr_o[13:0] == exp_addr(step_reg, restore_reg))
		else $error("wrong sequence address");
	a_six_steps: assert property (
		$fell(nv_busy_o) |-> step_reg == 3'h6)
		else $error("sequence not six steps");
	a_seq_no_write: assert property (
		nv_busy_o |-> we_n_o) else $error("write inside sequence");
	a_ce_addr_hold: assert property (
		!ce_n_o && !$past(ce_n_o) |-> $stable(addr_o))
		else $error("address moved while selected");
	a_ce_gap: assert property (
		$rose(ce_n_o) |=> ce_n_o) else $error("no deselect between steps");
	a_seq_top_bit: assert property (
		nv_busy_o && !ce_n_o |-> !addr_o[14])
		else $error("top address bit set in sequence");
	a_quiet_wait: assert property (
		nv_busy_o && step_reg == 3'h6 |-> ce_n_o && !dq_oe_o)
		else $error("pin activity during wait");
	a_wait_span: assert property (
		$fell(nv_busy_o) |->
		wait_cnt >= (restore_reg ? RECALL_CYC : STORE_CYC))
		else $error("wait shorter than nonvolatile cycle");
	a_busy_refuse: assert property (
		nv_busy_o |-> !cmd_ready_o) else $error("ready while busy");
	a_seq_read: assert property (
		nv_busy_o && !ce_n_o |-> !oe_n_o)
		else $error("sequence step not a read");
	c_save: cover property ($fell(nv_busy_o) && !restore_reg);
	c_restore: cover property ($fell(nv_busy_o) && restore_reg);
	c_write: cover property (!we_n_o && !ce_n_o);
endmodule : nvs_host_properties
bind nvs_host nvs_host_properties #(
	.STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC)
) u_props (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
	.cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
	.nv_busy_o(nv_busy_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
	.oe_n_o(oe_n_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o)
);
`default_nettype wire

// File: verif/nvs_mem_model.sv
// behavioural shadow memory answering the nvs host
`timescale 1ns/100ps
`default_nettype none
`include "nvs_consts.svh"
module nvs_mem_model #(
	parameter int OFF_NS = 300
) (
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [`NVS_ADDR_W-1:0] addr_i,
	input wire logic [`NVS_DATA_W-1:0] dq_i,
	output logic [`NVS_DATA_W-1:0] dq_o
);
	logic [7:0] sram [0:32767];
	logic [7:0] nv [0:32767];
	logic [13:0] seq [0:4] = '{`NVS_SEQ_A0, `NVS_SEQ_A1, `NVS_SEQ_A2,
		`NVS_SEQ_A3, `NVS_SEQ_A4};
	logic [7:0] last = 8'h00;
	logic sel = 1'b0;
	logic off = 1'b0;
	int step = 0;
	int save_cnt = 0;
	int restore_cnt = 0;
	// cells start known: unknown read data would never settle in the host
	initial begin
		foreach (sram[i]) begin
			sram[i] = 8'(i);
			nv[i] = 8'h00;
		end
	end
	always @(negedge ce_n_i) sel = 1'b1;
	always @(posedge off) #OFF_NS off = 1'b0;
	// a step counts only as its chip-enable cycle closes
	always @(posedge ce_n_i) begin
		if (sel && !off) begin
			if (!we_n_i) begin
				sram[addr_i] = dq_i;
				step = 0;
			end else if (step == 5 && (addr_i[13:0] == `NVS_SEQ_SAVE ||
				addr_i[13:0] == `NVS_SEQ_RESTORE)) begin
				if (addr_i[13:0] == `NVS_SEQ_SAVE) begin
					nv = sram;
					save_cnt++;
				end else begin
					foreach (sram[i]) sram[i] = 8'h00;
					sram = nv;
					restore_cnt++;
				end
				step = 0;
				off = 1'b1;
			end else if (step < 5 && addr_i[13:0] == seq[step]) begin
				step++;
			end else begin
				step = (addr_i[13:0] == `NVS_SEQ_A0) ? 1 : 0;
			end
		end
		sel = 1'b0;
	end
	always @* begin
		if (!ce_n_i && !oe_n_i && we_n_i && !off) begin
			dq_o = sram[addr_i];
			last = dq_o;
		end else begin
			// released bus has no pull: show a changed value
			dq_o = ~last;
		end
	end
endmodule : nvs_mem_model
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the nvs host against the memory model
`timescale 1ns/100ps
`default_nettype none
`include "nvs_consts.svh"
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd = 2'h0;
	logic [14:0] cmd_addr = 15'h0000;
	logic [7:0] wdata = 8'h00;
	logic ready, done, busy, ce_n, we_n, oe_n, dq_oe;
	logic [7:0] rdata, dq_h, dq_m;
	logic [14:0] addr;
	int error_cnt = 0;
	int cmp_count = 0;
	always #20 clk = ~clk;
	nvs_host #(.STORE_CYC(20), .RECALL_CYC(10)) u_nvs_host (
		.ref_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
		.cmd_i(cmd), .cmd_addr_i(cmd_addr), .cmd_wdata_i(wdata),
		.cmd_ready_o(ready), .done_o(done), .rdata_o(rdata),
		.nv_busy_o(busy), .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n),
		.addr_o(addr), .dq_o(dq_h), .dq_oe_o(dq_oe), .dq_i(dq_m));
	// device stays off for the recall time: a host that skips its wait
	// loses the write that follows a save
	nvs_mem_model #(.OFF_NS(10 * `NVS_CLK_NS)) u_nvs_mem_model (
		.ce_n_i(ce_n), .we_n_i(we_n),
		.oe_n_i(oe_n), .addr_i(addr), .dq_i(dq_h), .dq_o(dq_m));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("mismatches %0d, compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	task automatic issue(input logic [1:0] c, input logic [14:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cmd <= c;
		cmd_addr <= a;
		wdata <= d;
		cmd_valid <= 1'b1;
		do @(posedge clk); while (ready !== 1'b1);
		cmd_valid <= 1'b0;
		while (done !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (done !== 1'b1) begin
			error_cnt++;
			summarize();
		end
	endtask : issue
	// two cells apart only in the top address bit stay distinct
	task automatic t_write_read();
		issue(nvs_pkg::NVS_CMD_WRITE, 15'h0123, 8'h5A);
		issue(nvs_pkg::NVS_CMD_WRITE, 15'h4123, 8'hA5);
		issue(nvs_pkg::NVS_CMD_READ, 15'h0123, 8'h00);
		check(rdata, 8'h5A);
		issue(nvs_pkg::NVS_CMD_READ, 15'h4123, 8'h00);
		check(rdata, 8'hA5);
	endtask : t_write_read
	task automatic t_save();
		issue(nvs_pkg::NVS_CMD_WRITE, 15'h0123, 8'h3C);
		issue(nvs_pkg::NVS_CMD_SAVE, 15'h0000, 8'h00);
		check(8'(u_nvs_mem_model.save_cnt), 8'h01);
		check(u_nvs_mem_model.nv[15'h0123], 8'h3C);
		// a write right after the wait must land once the device is back
		issue(nvs_pkg::NVS_CMD_WRITE, 15'h0200, 8'h11);
		issue(nvs_pkg::NVS_CMD_READ, 15'h0200, 8'h00);
		check(rdata, 8'h11);
	endtask : t_save
	task automatic t_restore();
		issue(nvs_pkg::NVS_CMD_WRITE, 15'h0123, 8'hC3);
		issue(nvs_pkg::NVS_CMD_RESTORE, 15'h0000, 8'h00);
		check(8'(u_nvs_mem_model.restore_cnt), 8'h01);
		issue(nvs_pkg::NVS_CMD_READ, 15'h0123, 8'h00);
		check(rdata, 8'h3C);
		check(u_nvs_mem_model.nv[15'h0123], 8'h3C);
	endtask : t_restore
	task automatic t_again();
		issue(nvs_pkg::NVS_CMD_SAVE, 15'h0000, 8'h00);
		check(8'(u_nvs_mem_model.save_cnt), 8'h02);
		check({7'h00, busy}, 8'h00);
	endtask : t_again
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_write_read();
		t_save();
		t_restore();
		t_again();
		summarize();
	end
endmodule : testbench
`default_nettype wire
